/* src/power_seq_regs.v */
// Sequencing and input overcurrent limit command bank
//
// Behaviour
// - Overcurrent limit, amperes, resets 50, writes above 50 are clamped.
// - New overcurrent limit takes effect only at the commit command.
// - Turn-on delay in 10 us counts, resets to 200 us.
// - Turn-off delay in 10 us counts, resets zero, capped at 100 ms.
// - Rise time in microseconds, resets to 500 us.
// - Fall time in microseconds, 0 to 10000, resets to 500 us.
// - Rise ramp rate computed from voltage target at commit.
// - Fall ramp rate computed from voltage target at commit.
// - Overcurrent limit is one global value for both outputs.
// - Delay and ramp settings kept per output, chosen by page.
// - Each command except commit is a readable and writable two-byte word; commit reads as zero.
`timescale 1ns/1ps
`default_nettype none
`include "power_seq_defs.vh"
module power_seq_regs #(
	parameter PAGES = 2,
	parameter VOUT_W = 16
) (
	input wire clock_in, // System clock, 100 MHz
	input wire rstn_in, // Synchronous reset, active low
	input wire ce_in, // Clock enable, freezes state when low
	input wire [7:0] cmd_in, // Command code of the transaction
	input wire wr_in, // Write strobe, one cycle
	input wire rd_in, // Read strobe, one cycle
	input wire [15:0] wdata_in, // Write word
	input wire [VOUT_W-1:0] vout_target_in, // Output voltage target
	input wire [PAGES-1:0] enable_pin_in, // Output enable pins
	output reg [15:0] rdata_out, // Read word
	output reg rvalid_out, // Read data valid, one cycle
	output reg ack_out, // Command accepted, one cycle
	output reg nack_out, // Unknown command, one cycle
	output reg [15:0] active_oc_limit_out, // Committed overcurrent limit
	output reg [PAGES*VOUT_W-1:0] rise_rate_out, // Committed rise rate
	output reg [PAGES*VOUT_W-1:0] fall_rate_out, // Committed fall rate
	output reg [PAGES*2-1:0] phase_out, // Sequencer phase per output
	output reg [PAGES-1:0] ramping_out, // Ramp in progress per output
	output reg [PAGES-1:0] power_on_out // Output regulating per output
);
	localparam PW = (PAGES > 1) ? $clog2(PAGES) : 1;
	reg [15:0] oc_limit;
	reg [15:0] on_delay [0:PAGES-1];
	reg [15:0] on_ramp [0:PAGES-1];
	reg [15:0] off_delay [0:PAGES-1];
	reg [15:0] off_ramp [0:PAGES-1];
	reg [PW-1:0] page;
	reg [PAGES-1:0] en_s1, en_s2, en_s3, en_q;
	wire [PAGES*2-1:0] seq_phase;
	wire [PAGES-1:0] seq_ramp, seq_on;
	wire page_ok = ({{(16-PW){1'b0}}, page} < PAGES);
	reg [15:0] rd_word;
	reg known;
	// Clamped write words, chosen ahead of the command bank
	reg [15:0] next_oc_limit;
	reg [15:0] next_off_delay;
	reg [15:0] next_off_ramp;
	// Rates worked out for every page, latched only at commit
	wire [PAGES*VOUT_W-1:0] next_rise_rate;
	wire [PAGES*VOUT_W-1:0] next_fall_rate;
	// Quotient width: the wider of the target and the ramp word
	localparam QW = (VOUT_W > 16) ? VOUT_W : 16;
	wire [QW+VOUT_W-1:0] target_pad = {{QW{1'b0}}, vout_target_in};
	wire [QW-1:0] target_w = target_pad[QW-1:0];
	integer i;
	// ====================================================
	// Enable pin synchroniser: change taken when stages 2 and 3 agree
	always @(posedge clock_in) begin
		if (!rstn_in) begin
			en_s1 <= {PAGES{1'b0}};
			en_s2 <= {PAGES{1'b0}};
			en_s3 <= {PAGES{1'b0}};
			en_q <= {PAGES{1'b0}};
		end else if (ce_in) begin
			en_s1 <= enable_pin_in;
			en_s2 <= en_s1;
			en_s3 <= en_s2;
			// A lone disagreeing sample keeps the last level
			en_q <= (en_s2 & en_s3) | (en_q & (en_s2 | en_s3));
		end
	end
	// ====================================================
	// Read decode
	always @* begin
		rd_word = 16'h0000;
		known = 1'b1;
		case (cmd_in)
		`CMD_PAGE: rd_word = {{(16-PW){1'b0}}, page};
		`CMD_COMMIT: rd_word = 16'h0000;
		`CMD_IIN_OC_LIMIT: rd_word = oc_limit;
		// A page beyond the implemented count reads as zero
		`CMD_ON_DELAY: if (page_ok)
			rd_word = on_delay[page];
		`CMD_ON_RAMP: if (page_ok)
			rd_word = on_ramp[page];
		`CMD_OFF_DELAY: if (page_ok)
			rd_word = off_delay[page];
		`CMD_OFF_RAMP: if (page_ok)
			rd_word = off_ramp[page];
		default: known = 1'b0;
		endcase
	end
	// ====================================================
	// Write clamps: a word above its range is held at the top
	always @* begin
		next_oc_limit = wdata_in;
		next_off_delay = wdata_in;
		next_off_ramp = wdata_in;
		if (wdata_in > `MAX_IIN_OC_LIMIT)
			next_oc_limit = `MAX_IIN_OC_LIMIT;
		if (wdata_in > `MAX_OFF_DELAY)
			next_off_delay = `MAX_OFF_DELAY;
		if (wdata_in > `MAX_OFF_RAMP)
			next_off_ramp = `MAX_OFF_RAMP;
	end
	// ====================================================
	// Ramp rates: target per ramp microsecond, from the present target
	genvar r;
	generate
		for (r = 0; r < PAGES; r = r + 1) begin : rate
			wire [QW+15:0] rise_pad;
			wire [QW+15:0] fall_pad;
			wire [QW-1:0] rise_q;
			wire [QW-1:0] fall_q;
			assign rise_pad = {{QW{1'b0}}, on_ramp[r]};
			assign fall_pad = {{QW{1'b0}}, off_ramp[r]};
			// A zero ramp is a step: the whole target at once
			assign rise_q = (on_ramp[r] == 16'h0000) ? target_w :
				target_w / rise_pad[QW-1:0];
			assign fall_q = (off_ramp[r] == 16'h0000) ? target_w :
				target_w / fall_pad[QW-1:0];
			// Rate never exceeds the target, so the cut is exact
			assign next_rise_rate[r*VOUT_W +: VOUT_W] =
				rise_q[VOUT_W-1:0];
			assign next_fall_rate[r*VOUT_W +: VOUT_W] =
				fall_q[VOUT_W-1:0];
		end
	endgenerate
	// ====================================================
	// Command bank
	always @(posedge clock_in) begin
		if (!rstn_in) begin
			oc_limit <= `RST_IIN_OC_LIMIT;
			active_oc_limit_out <= `RST_IIN_OC_LIMIT;
			page <= {PW{1'b0}};
			for (i = 0; i < PAGES; i = i + 1) begin
				on_delay[i] <= `RST_ON_DELAY;
				on_ramp[i] <= `RST_ON_RAMP;
				off_delay[i] <= `RST_OFF_DELAY;
				off_ramp[i] <= `RST_OFF_RAMP;
			end
			rise_rate_out <= {PAGES*VOUT_W{1'b0}};
			fall_rate_out <= {PAGES*VOUT_W{1'b0}};
			rdata_out <= 16'h0000;
			rvalid_out <= 1'b0;
			ack_out <= 1'b0;
			nack_out <= 1'b0;
		end else if (ce_in) begin
			rvalid_out <= rd_in && known;
			ack_out <= (rd_in || wr_in) && known;
			nack_out <= (rd_in || wr_in) && !known;
			if (rd_in)
				rdata_out <= rd_word;
			// Delays and ramps reach the sequencers at once;
			// only the limit and the rates wait for commit
			if (wr_in) begin
				case (cmd_in)
				`CMD_PAGE: page <= wdata_in[PW-1:0];
				`CMD_IIN_OC_LIMIT:
					oc_limit <= next_oc_limit;
				`CMD_ON_DELAY: if (page_ok)
					on_delay[page] <= wdata_in;
				`CMD_ON_RAMP: if (page_ok)
					on_ramp[page] <= wdata_in;
				`CMD_OFF_DELAY: if (page_ok)
					off_delay[page] <= next_off_delay;
				`CMD_OFF_RAMP: if (page_ok)
					off_ramp[page] <= next_off_ramp;
				`CMD_COMMIT: begin
					active_oc_limit_out <= oc_limit;
					rise_rate_out <= next_rise_rate;
					fall_rate_out <= next_fall_rate;
				end
				default: ;
				endcase
			end
		end
	end
	// ====================================================
	// Per-output sequencers
	genvar g;
	generate
		for (g = 0; g < PAGES; g = g + 1) begin : seq
			output_sequencer u_seq (
				.clock_in(clock_in),
				.rstn_in(rstn_in),
				.ce_in(ce_in),
				.enable_in(en_q[g]),
				.on_delay_in(on_delay[g]),
				.on_ramp_in(on_ramp[g]),
				.off_delay_in(off_delay[g]),
				.off_ramp_in(off_ramp[g]),
				.phase_out(seq_phase[g*2 +: 2]),
				.ramping_out(seq_ramp[g]),
				.power_on_out(seq_on[g])
			);
		end
	endgenerate
	// ====================================================
	// Output registers, one stage behind the sequencers
	always @(posedge clock_in) begin
		if (!rstn_in) begin
			phase_out <= {PAGES*2{1'b0}};
			ramping_out <= {PAGES{1'b0}};
			power_on_out <= {PAGES{1'b0}};
		end else if (ce_in) begin
			phase_out <= seq_phase;
			ramping_out <= seq_ramp;
			power_on_out <= seq_on;
		end
	end
endmodule
`default_nettype wire

/* src/power_seq_defs.vh */
// Command codes, reset values and timing constants of the sequencing bank
`ifndef POWER_SEQ_DEFS_VH
`define POWER_SEQ_DEFS_VH
`define CMD_IIN_OC_LIMIT 8'h5B
`define CMD_ON_DELAY 8'h60
`define CMD_ON_RAMP 8'h61
`define CMD_OFF_DELAY 8'h64
`define CMD_OFF_RAMP 8'h65
`define CMD_PAGE 8'h00
`define CMD_COMMIT 8'hE7
`define RST_IIN_OC_LIMIT 16'h0032
`define MAX_IIN_OC_LIMIT 16'h0032
`define RST_ON_DELAY 16'h0014
`define RST_ON_RAMP 16'h01F4
`define RST_OFF_DELAY 16'h0000
`define MAX_OFF_DELAY 16'h2710
`define RST_OFF_RAMP 16'h01F4
`define MAX_OFF_RAMP 16'h2710
`define DELAY_STEP_US 10
`define RAMP_STEP_US 1
`define CLOCK_MHZ 100
`define DELAY_TICK_CYCLES (`DELAY_STEP_US * `CLOCK_MHZ)
`define RAMP_TICK_CYCLES (`RAMP_STEP_US * `CLOCK_MHZ)
`endif

/* src/output_sequencer.v */
// One output's delay and ramp sequencer
`timescale 1ns/1ps
`default_nettype none
`include "power_seq_defs.vh"
module output_sequencer #(
	parameter DELAY_TICK = `DELAY_TICK_CYCLES,
	parameter RAMP_TICK = `RAMP_TICK_CYCLES
) (
	input wire clock_in, // System clock
	input wire rstn_in, // Synchronous reset, active low
	input wire ce_in, // Clock enable
	input wire enable_in, // Output enable, synchronised
	input wire [15:0] on_delay_in, // Turn-on delay, 10 us counts
	input wire [15:0] on_ramp_in, // Rise time, us
	input wire [15:0] off_delay_in, // Turn-off delay, 10 us counts
	input wire [15:0] off_ramp_in, // Fall time, us
	output reg [1:0] phase_out, // 0 off, 1 on or off delay, 2 rise or fall ramp, 3 on
	output reg ramping_out, // Ramp in progress
	output reg power_on_out // Output regulating
);
	localparam S_OFF = 3'h0;
	localparam S_ONDLY = 3'h1;
	localparam S_RISE = 3'h2;
	localparam S_ON = 3'h3;
	localparam S_OFFDLY = 3'h4;
	localparam S_FALL = 3'h5;
	reg [2:0] state;
	reg [15:0] units;
	reg [15:0] tick;
	wire delay_st = (state == S_ONDLY) || (state == S_OFFDLY);
	wire tick_done = delay_st ? (tick == DELAY_TICK - 1) :
		(tick == RAMP_TICK - 1);
	wire unit_done = tick_done && (units <= 16'h0001);
	// ====================================================
	// Sequencing
	always @(posedge clock_in) begin
		if (!rstn_in) begin
			state <= S_OFF;
			units <= 16'h0000;
			tick <= 16'h0000;
			phase_out <= 2'h0;
			ramping_out <= 1'b0;
			power_on_out <= 1'b0;
		end else if (ce_in) begin
			tick <= tick_done ? 16'h0000 : tick + 16'h0001;
			if (tick_done && units != 16'h0000)
				units <= units - 16'h0001;
			case (state)
			S_OFF: begin
				tick <= 16'h0000;
				if (enable_in) begin
					state <= S_ONDLY;
					units <= on_delay_in;
				end
			end
			S_ONDLY: begin
				if (!enable_in) begin
					state <= S_OFF;
				end else if (units == 16'h0000 || unit_done) begin
					state <= S_RISE;
					units <= on_ramp_in;
					tick <= 16'h0000;
				end
			end
			S_RISE: begin
				if (units == 16'h0000 || unit_done) begin
					state <= S_ON;
				end
			end
			S_ON: begin
				tick <= 16'h0000;
				if (!enable_in) begin
					state <= S_OFFDLY;
					units <= off_delay_in;
				end
			end
			S_OFFDLY: begin
				if (enable_in) begin
					state <= S_ON;
				end else if (units == 16'h0000 || unit_done) begin
					state <= S_FALL;
					units <= off_ramp_in;
					tick <= 16'h0000;
				end
			end
			S_FALL: begin
				if (units == 16'h0000 || unit_done) begin
					state <= S_OFF;
				end
			end
			default: state <= S_OFF;
			endcase
			phase_out <= (state == S_ON) ? 2'h3 :
				(state == S_RISE || state == S_FALL) ? 2'h2 :
				(state == S_OFF) ? 2'h0 : 2'h1;
			ramping_out <= (state == S_RISE) || (state == S_FALL);
			power_on_out <= (state == S_ON);
		end
	end
endmodule
`default_nettype wire

/* tb/power_seq_monitor.sv */
// Checker of the sequencing command bank
`timescale 1ns/1ps
`default_nettype none
`include "power_seq_defs.vh"
module power_seq_monitor #(parameter PAGES = 2, parameter VOUT_W = 16) (
	input wire clock_in, // Clock
	input wire rstn_in, // Reset, active low
	input wire ce_in, // Clock enable
	input wire [7:0] cmd_in, // Command code
	input wire wr_in, // Write strobe
	input wire rd_in, // Read strobe
	input wire [15:0] rdata_out, // Read word
	input wire rvalid_out, // Read valid
	input wire ack_out, // Accepted
	input wire nack_out, // Refused
	input wire [15:0] active_oc_limit_out, // Committed limit
	input wire [PAGES*VOUT_W-1:0] rise_rate_out, // Rise rates
	input wire [PAGES*VOUT_W-1:0] fall_rate_out // Fall rates
);
	// ==========
	// Properties
	wire kn = cmd_in inside {`CMD_IIN_OC_LIMIT, `CMD_ON_DELAY, `CMD_ON_RAMP,
		`CMD_OFF_DELAY, `CMD_OFF_RAMP, `CMD_PAGE, `CMD_COMMIT};
	wire cm = ce_in && wr_in && cmd_in == `CMD_COMMIT;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	a_known_ack: assert property (ce_in && (wr_in || rd_in) && kn |=> ack_out && !nack_out) else $error("no ack");
	a_unknown_nack: assert property (ce_in && (wr_in || rd_in) && !kn |=> nack_out && !ack_out && !rvalid_out) else $error("no nack");
	a_read_valid: assert property (ce_in && rd_in && kn |=> rvalid_out) else $error("no read data");
	a_read_hold: assert property (ce_in && !rd_in |=> !rvalid_out && $stable(rdata_out)) else $error("stray read");
	a_limit_commit: assert property (ce_in && !cm |=> $stable(active_oc_limit_out)) else $error("limit moved");
	a_limit_range: assert property (active_oc_limit_out <= `MAX_IIN_OC_LIMIT) else $error("limit high");
	a_rate_commit: assert property (ce_in && !cm |=> $stable(rise_rate_out) && $stable(fall_rate_out)) else $error("rate moved");
	a_reset_state: assert property ($rose(rstn_in) |-> active_oc_limit_out == `RST_IIN_OC_LIMIT && rdata_out == 16'h0000) else $error("bad reset");
	c_commit: cover property (cm);
	c_nack: cover property (nack_out);
	c_read: cover property (rvalid_out && rdata_out == `RST_ON_DELAY);
endmodule
bind power_seq_regs power_seq_monitor #(.PAGES(PAGES), .VOUT_W(VOUT_W))
	u_power_seq_monitor (.clock_in(clock_in), .rstn_in(rstn_in),
	.ce_in(ce_in), .cmd_in(cmd_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .rvalid_out(rvalid_out), .ack_out(ack_out),
	.nack_out(nack_out), .active_oc_limit_out(active_oc_limit_out),
	.rise_rate_out(rise_rate_out), .fall_rate_out(fall_rate_out));
`default_nettype wire

/* tb/pmbus_host_model.sv */
// Host model issuing command transfers
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
	input wire logic clock_in, // Clock
	input wire logic [15:0] rdata_in, // Read word
	input wire logic nack_in, // Refused
	output logic [7:0] cmd_out, // Command code
	output logic wr_out, // Write strobe
	output logic rd_out, // Read strobe
	output logic [15:0] wdata_out // Write word
);
	// ==========
	// Transfers
	initial begin
		cmd_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 16'h0000;
	end
	task xfer(input logic rd, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] q, output logic nk);
		@(posedge clock_in);
		cmd_out <= c;
		wr_out <= !rd;
		rd_out <= rd;
		wdata_out <= d;
		@(posedge clock_in);
		wr_out <= 1'b0;
		rd_out <= 1'b0;
		wdata_out <= ~d;
		#1;
		q = rdata_in;
		nk = nack_in;
	endtask
endmodule
`default_nettype wire

/* tb/power_sequencing_limit_registers_tb_top.sv */
// Testbench of the sequencing command bank
`timescale 1ns/1ps
`default_nettype none
`include "power_seq_defs.vh"
module power_sequencing_limit_registers_tb_top;
	// ==========
	// Bench
	logic clock_in, rstn_in, ce_in, wr_in, rd_in, rvalid_out, ack_out;
	logic nack_out, nk;
	logic [7:0] cmd_in;
	logic [15:0] wdata_in, vout_target_in, rdata_out, active_oc_limit_out, q;
	logic [1:0] enable_pin_in, ramping_out, power_on_out;
	logic [3:0] phase_out;
	logic [31:0] rise_rate_out, fall_rate_out;
	int fails = 0;
	int total_checks = 0;
	power_seq_regs u_power_seq_regs (.clock_in(clock_in), .rstn_in(rstn_in),
		.ce_in(ce_in), .cmd_in(cmd_in), .wr_in(wr_in), .rd_in(rd_in),
		.wdata_in(wdata_in), .vout_target_in(vout_target_in),
		.enable_pin_in(enable_pin_in), .rdata_out(rdata_out),
		.rvalid_out(rvalid_out), .ack_out(ack_out), .nack_out(nack_out),
		.active_oc_limit_out(active_oc_limit_out),
		.rise_rate_out(rise_rate_out), .fall_rate_out(fall_rate_out),
		.phase_out(phase_out), .ramping_out(ramping_out),
		.power_on_out(power_on_out));
	pmbus_host_model u_pmbus_host_model (.clock_in(clock_in),
		.rdata_in(rdata_out), .nack_in(nack_out), .cmd_out(cmd_in),
		.wr_out(wr_in), .rd_out(rd_in), .wdata_out(wdata_in));
	task report_and_stop;
		if (fails == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, g);
			fails++;
		end
	endtask
	task wr(input logic [7:0] c, input logic [15:0] d);
		u_pmbus_host_model.xfer(1'b0, c, d, q, nk);
	endtask
	task rdchk(input logic [7:0] c, input logic [15:0] e);
		u_pmbus_host_model.xfer(1'b1, c, 16'h0000, q, nk);
		chk($sformatf("cmd %h", c), e, q);
	endtask
	task t_reset;
		chk("limit", 16'h0032, active_oc_limit_out);
		rdchk(8'h5B, 16'h0032);
		rdchk(8'h60, 16'h0014);
		rdchk(8'h61, 16'h01F4);
		rdchk(8'h64, 16'h0000);
		rdchk(8'h65, 16'h01F4);
		u_pmbus_host_model.xfer(1'b1, 8'h7A, 16'h0000, q, nk);
		chk("nack", 16'h0001, {15'h0000, nk});
	endtask
	task t_limit;
		wr(8'h5B, 16'h0020);
		rdchk(8'h5B, 16'h0020);
		chk("limit", 16'h0032, active_oc_limit_out);
		wr(`CMD_COMMIT, 16'h0000);
		chk("limit", 16'h0020, active_oc_limit_out);
		wr(8'h5B, 16'h0040);
		wr(`CMD_PAGE, 16'h0001);
		rdchk(8'h5B, 16'h0032);
		chk("limit", 16'h0020, active_oc_limit_out);
	endtask
	task t_paged;
		wr(8'h60, 16'h0001);
		wr(8'h61, 16'h0001);
		wr(8'h64, 16'h3000);
		rdchk(8'h64, 16'h2710);
		wr(8'h64, 16'h0001);
		wr(8'h65, 16'h3000);
		rdchk(8'h65, 16'h2710);
		wr(8'h65, 16'h0002);
		wr(`CMD_PAGE, 16'h0000);
		rdchk(8'h60, 16'h0014);
		rdchk(8'h64, 16'h0000);
	endtask
	task t_rates;
		@(posedge clock_in);
		vout_target_in <= 16'h1000;
		wr(`CMD_COMMIT, 16'h0000);
		chk("rise0", 16'h0008, rise_rate_out[15:0]);
		chk("rise1", 16'h1000, rise_rate_out[31:16]);
		chk("fall1", 16'h0800, fall_rate_out[31:16]);
		@(posedge clock_in);
		vout_target_in <= 16'h2000;
		wr(8'h60, 16'h0014);
		chk("fall0", 16'h0008, fall_rate_out[15:0]);
		wr(`CMD_COMMIT, 16'h0000);
		chk("fall0", 16'h0010, fall_rate_out[15:0]);
	endtask
	task t_seq;
		@(posedge clock_in);
		enable_pin_in <= 2'b10;
		repeat (900) @(posedge clock_in);
		#1;
		chk("phase", 16'h0004, {12'h000, phase_out});
		chk("on", 16'h0000, {14'h0000, power_on_out});
		repeat (150) @(posedge clock_in);
		#1;
		chk("ramp", 16'h0002, {14'h0000, ramping_out});
		chk("phase", 16'h0008, {12'h000, phase_out});
		repeat (150) @(posedge clock_in);
		#1;
		chk("on", 16'h0002, {14'h0000, power_on_out});
		chk("phase", 16'h000C, {12'h000, phase_out});
		@(posedge clock_in);
		enable_pin_in <= 2'b00;
		repeat (900) @(posedge clock_in);
		#1;
		chk("phase", 16'h0004, {12'h000, phase_out});
		chk("on", 16'h0000, {14'h0000, power_on_out});
		repeat (200) @(posedge clock_in);
		#1;
		chk("ramp", 16'h0002, {14'h0000, ramping_out});
		repeat (200) @(posedge clock_in);
		#1;
		chk("phase", 16'h0000, {12'h000, phase_out});
		chk("ramp", 16'h0000, {14'h0000, ramping_out});
	endtask
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	initial begin
		#100000;
		fails++;
		report_and_stop;
	end
	initial begin
		rstn_in = 1'b0;
		ce_in = 1'b1;
		vout_target_in = 16'h0000;
		enable_pin_in = 2'b00;
		repeat (2) @(posedge clock_in);
		rstn_in <= 1'b1;
		@(posedge clock_in);
		#1;
		t_reset;
		t_limit;
		t_paged;
		t_rates;
		t_seq;
		report_and_stop;
	end
endmodule
`default_nettype wire
